// *** src/crc_pkg.sv ***
package crc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_POLY = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam int OFF_W = 8;

  // reset values
  localparam logic [31:0] RST_DATA = 32'hffff_ffff;
  localparam logic [31:0] RST_POLY = 32'h0000_1021;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // control fields live in the top byte of the control word
  localparam int CTRL_LSB = 24;
  localparam int CTRL_W = 8;
  localparam int CTRL_LANE = 3;

  localparam logic [31:0] HALF_MASK = 32'h0000_ffff;
  localparam logic [31:0] FULL_MASK = 32'hffff_ffff;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 4;

  // clocks spent on one byte of the calculation
  localparam int STEP_CYCLES = 2;

  typedef enum logic [1:0] {
    XP_NONE = 2'b00,
    XP_BITS = 2'b01,
    XP_BOTH = 2'b10,
    XP_BYTES = 2'b11
  } xpose_t;

  typedef struct packed {
    xpose_t writeTransposeSel;
    xpose_t readTransposeSel;
    logic rsvd;
    logic resultInvert;
    logic seedWriteSelect;
    logic crcWidthSelect;
  } ctrl_t;

  // a data word waiting to be folded into the checksum
  typedef struct packed {
    logic [31:0] word;
    logic [3:0] lanes;
  } job_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_STEP = 2'b11
  } state_t;

endpackage

// *** src/crc_control_config.sv ***
`timescale 1ns/1ps
`default_nettype none

module crc_control_config #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  if (ADDR_W < crc_pkg::OFF_W) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  function automatic logic [31:0] xposeWord(input logic [31:0] w, input crc_pkg::xpose_t t);
    logic [31:0] bitsIn;
    logic [31:0] full;
    bitsIn = '0;
    full = '0;
    for (int i = 0; i < 32; i++) begin
      bitsIn[i] = w[(i / 8) * 8 + 7 - (i % 8)];
      full[i] = w[31 - i];
    end
    case (t)
      crc_pkg::XP_BITS: return bitsIn;
      crc_pkg::XP_BOTH: return full;
      crc_pkg::XP_BYTES: return {w[7:0], w[15:8], w[23:16], w[31:24]};
      default: return w;
    endcase
  endfunction

  // byte lanes move with the bytes when the byte order is reversed
  function automatic logic [3:0] xposeLanes(input logic [3:0] l, input crc_pkg::xpose_t t);
    if (t == crc_pkg::XP_BOTH || t == crc_pkg::XP_BYTES) begin
      return {l[0], l[1], l[2], l[3]};
    end
    return l;
  endfunction

  function automatic logic [31:0] laneMask(input logic [3:0] l);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < crc_pkg::LANES; i++) begin
      m[i * 8 +: 8] = {8{l[i]}};
    end
    return m;
  endfunction

  // one byte through the shift register, msb first
  function automatic logic [31:0] crcByte(input logic [31:0] crc, input logic [31:0] poly,
                                          input logic [7:0] b, input logic wide);
    logic [31:0] c;
    logic top;
    c = wide ? (crc ^ {b, 24'h00_0000}) : ((crc & crc_pkg::HALF_MASK) ^ {16'h0000, b, 8'h00});
    for (int i = 0; i < crc_pkg::BYTE_W; i++) begin
      top = wide ? c[31] : c[15];
      c = top ? ({c[30:0], 1'b0} ^ poly) : {c[30:0], 1'b0};
    end
    return wide ? c : (c & crc_pkg::HALF_MASK);
  endfunction

  crc_pkg::state_t stateReg, stateNext;
  crc_pkg::ctrl_t ctrlReg, ctrlNext;
  crc_pkg::job_t jobReg, jobNext;
  logic [31:0] crcReg, crcNext;
  logic [31:0] polyReg, polyNext;
  logic [31:0] datOReg, datONext;
  logic [7:0] curByteReg, curByteNext;
  logic ackReg, ackNext;

  logic req;
  logic [7:0] off;
  logic [31:0] wordX;
  logic [3:0] lanesX;
  logic [31:0] widthMask;
  logic [31:0] rawRead;
  logic [31:0] seedMerged;
  logic [1:0] pickIdx;

  assign off = {wb_adr_i[crc_pkg::OFF_W-1:2], 2'b00};
  assign req = wb_cyc_i && wb_stb_i && !ackReg && (stateReg == crc_pkg::ST_IDLE);
  // narrow writes see zeros in the unused lanes before transposition
  assign wordX = xposeWord(wb_dat_i & laneMask(wb_sel_i), ctrlReg.writeTransposeSel);
  assign lanesX = xposeLanes(wb_sel_i, ctrlReg.writeTransposeSel);
  assign widthMask = ctrlReg.crcWidthSelect ? crc_pkg::FULL_MASK : crc_pkg::HALF_MASK;
  assign rawRead = crcReg & widthMask;
  assign seedMerged = (crcReg & ~laneMask(lanesX)) | (wordX & laneMask(lanesX));

  always_comb begin
    stateNext = stateReg;
    ctrlNext = ctrlReg;
    jobNext = jobReg;
    crcNext = crcReg;
    polyNext = polyReg;
    datONext = datOReg;
    curByteNext = curByteReg;
    ackNext = 1'b0;
    pickIdx = 2'b00;
    case (stateReg)
      crc_pkg::ST_IDLE: begin
        if (req) begin
          ackNext = 1'b1;
          datONext = '0;
          if (off == crc_pkg::OFF_DATA) begin
            if (!wb_we_i) begin
              // complement over the active width, then the read transposition
              datONext = xposeWord(rawRead ^ (ctrlReg.resultInvert ? widthMask : '0),
                                   ctrlReg.readTransposeSel);
            end else if (ctrlReg.seedWriteSelect) begin
              crcNext = seedMerged & widthMask;
            end else if (lanesX != 4'h0) begin
              // bus stays stalled until every valid byte is folded in
              ackNext = 1'b0;
              jobNext = '{word: wordX, lanes: lanesX};
              stateNext = crc_pkg::ST_LOAD;
            end
          end else if (off == crc_pkg::OFF_POLY) begin
            if (wb_we_i) begin
              for (int i = 0; i < crc_pkg::LANES; i++) begin
                if (wb_sel_i[i] && (i < 2 || ctrlReg.crcWidthSelect)) begin
                  polyNext[i * 8 +: 8] = wb_dat_i[i * 8 +: 8];
                end
              end
            end else begin
              datONext = polyReg;
            end
          end else if (off == crc_pkg::OFF_CTRL) begin
            if (wb_we_i && wb_sel_i[crc_pkg::CTRL_LANE]) begin
              ctrlNext = crc_pkg::ctrl_t'(wb_dat_i[crc_pkg::CTRL_LSB +: crc_pkg::CTRL_W]);
              ctrlNext.rsvd = 1'b0;
            end else if (!wb_we_i) begin
              datONext = {ctrlReg, 24'h00_0000};
            end
          end
        end
      end
      crc_pkg::ST_LOAD: begin
        // most significant valid byte goes first
        for (int i = 0; i < crc_pkg::LANES; i++) begin
          if (jobReg.lanes[i]) begin
            pickIdx = 2'(i);
          end
        end
        curByteNext = jobReg.word[pickIdx * 8 +: 8];
        jobNext.lanes[pickIdx] = 1'b0;
        stateNext = crc_pkg::ST_STEP;
      end
      crc_pkg::ST_STEP: begin
        crcNext = crcByte(crcReg, polyReg, curByteReg, ctrlReg.crcWidthSelect);
        if (jobReg.lanes == 4'h0) begin
          stateNext = crc_pkg::ST_IDLE;
          ackNext = 1'b1;
        end else begin
          stateNext = crc_pkg::ST_LOAD;
        end
      end
      default: begin
        stateNext = crc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= crc_pkg::ST_IDLE;
      ctrlReg <= crc_pkg::ctrl_t'(crc_pkg::RST_CTRL);
      jobReg <= '0;
      crcReg <= crc_pkg::RST_DATA;
      polyReg <= crc_pkg::RST_POLY;
      datOReg <= '0;
      curByteReg <= '0;
      ackReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      ctrlReg <= ctrlNext;
      jobReg <= jobNext;
      crcReg <= crcNext;
      polyReg <= polyNext;
      datOReg <= datONext;
      curByteReg <= curByteNext;
      ackReg <= ackNext;
    end
  end

  assign wb_dat_o = datOReg;
  assign wb_ack_o = ackReg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic accData;
  logic accCtrl;
  assign accData = req && off == crc_pkg::OFF_DATA;
  assign accCtrl = req && off == crc_pkg::OFF_CTRL;

  a_ack_single: assert property (ackReg |=> !ackReg)
    else $error("ack held longer than one cycle");

  a_ctrl_reserved: assert property (ctrlReg.rsvd == 1'b0)
    else $error("reserved control bit became set");

  a_ctrl_readback: assert property (accCtrl && !wb_we_i
    |=> wb_dat_o[31:24] == $past(ctrlReg) && wb_dat_o[27] == 1'b0 && wb_dat_o[23:0] == 24'h00_0000)
    else $error("control read does not return fields with zero reserved bits");

  a_ctrl_write: assert property (accCtrl && wb_we_i && wb_sel_i[3]
    |=> ctrlReg == {$past(wb_dat_i[31:28]), 1'b0, $past(wb_dat_i[26:24])} ##1 !ackReg)
    else $error("control write not stored");

  a_ctrl_ignored: assert property (accCtrl && wb_we_i && !wb_sel_i[3]
    |=> ctrlReg == $past(ctrlReg))
    else $error("control write without the top lane changed the fields");

  a_seed_load: assert property (accData && wb_we_i && ctrlReg.seedWriteSelect
    && ctrlReg.crcWidthSelect && wb_sel_i == 4'hf
    |=> crcReg == xposeWord($past(wb_dat_i), $past(ctrlReg.writeTransposeSel)) && ackReg)
    else $error("seed write did not load the transposed seed");

  a_seed_half: assert property (accData && wb_we_i && ctrlReg.seedWriteSelect
    && !ctrlReg.crcWidthSelect
    |=> crcReg[31:16] == 16'h0000)
    else $error("16-bit seed left bits in the upper half");

  a_seed_quick: assert property (accData && wb_we_i && ctrlReg.seedWriteSelect
    |=> ackReg && stateReg == crc_pkg::ST_IDLE)
    else $error("seed write started a calculation");

  a_word_timing: assert property (accData && wb_we_i && !ctrlReg.seedWriteSelect
    && wb_sel_i == 4'hf
    |=> (!ackReg && stateReg != crc_pkg::ST_IDLE) [*8] ##1 ackReg)
    else $error("full data word not folded in eight clocks");

  a_byte_timing: assert property (accData && wb_we_i && !ctrlReg.seedWriteSelect
    && $countones(wb_sel_i) == 1
    |=> (!ackReg) [*2] ##1 ackReg)
    else $error("single byte not folded in two clocks");

  a_byte_two_clocks: assert property (stateReg == crc_pkg::ST_LOAD
    |=> stateReg == crc_pkg::ST_STEP ##1 stateReg != crc_pkg::ST_STEP)
    else $error("byte step did not take two clocks");

  a_invert_read: assert property (accData && !wb_we_i
    && ctrlReg.readTransposeSel == crc_pkg::XP_NONE && ctrlReg.resultInvert
    |=> wb_dat_o == ($past(ctrlReg.crcWidthSelect) ? ~$past(crcReg) : {16'h0000, ~$past(crcReg[15:0])}))
    else $error("inverted read wrong");

  a_plain_read: assert property (accData && !wb_we_i
    && ctrlReg.readTransposeSel == crc_pkg::XP_NONE && !ctrlReg.resultInvert
    |=> wb_dat_o == ($past(ctrlReg.crcWidthSelect) ? $past(crcReg) : {16'h0000, $past(crcReg[15:0])}))
    else $error("raw read wrong");

  a_read_keeps_crc: assert property (accData && !wb_we_i
    |=> crcReg == $past(crcReg))
    else $error("data read altered the stored checksum");

  a_narrow_read: assert property (accData && !wb_we_i && !ctrlReg.crcWidthSelect
    && ctrlReg.readTransposeSel inside {crc_pkg::XP_NONE, crc_pkg::XP_BITS}
    |=> wb_dat_o[31:16] == 16'h0)
    else $error("16-bit read leaked upper half");

  a_bytes_read: assert property (accData && !wb_we_i && !ctrlReg.resultInvert
    && ctrlReg.readTransposeSel == crc_pkg::XP_BYTES
    |=> wb_dat_o == {$past(rawRead[7:0]), $past(rawRead[15:8]), $past(rawRead[23:16]), $past(rawRead[31:24])})
    else $error("byte-swapped read wrong");

  a_poly_high_locked: assert property (req && off == crc_pkg::OFF_POLY && wb_we_i
    && !ctrlReg.crcWidthSelect
    |=> polyReg[31:16] == $past(polyReg[31:16]))
    else $error("polynomial upper half written in 16-bit mode");

  a_poly_low_write: assert property (req && off == crc_pkg::OFF_POLY && wb_we_i
    && wb_sel_i[1:0] == 2'b11
    |=> polyReg[15:0] == $past(wb_dat_i[15:0]))
    else $error("polynomial lower half not written");

  c_seed_then_data: cover property (accData && wb_we_i && ctrlReg.seedWriteSelect
    ##[1:20] accData && wb_we_i && !ctrlReg.seedWriteSelect);

  c_byte_write: cover property (accData && wb_we_i && !ctrlReg.seedWriteSelect && $countones(wb_sel_i) == 1);

  c_inverted_read: cover property (accData && !wb_we_i && ctrlReg.resultInvert
    && ctrlReg.readTransposeSel == crc_pkg::XP_BOTH);

  c_word_write: cover property (accData && wb_we_i && !ctrlReg.seedWriteSelect && wb_sel_i == 4'hf);

  c_reversed_write: cover property (accData && wb_we_i && !ctrlReg.seedWriteSelect
    && ctrlReg.writeTransposeSel == crc_pkg::XP_BOTH);

endmodule // crc_control_config

`default_nettype wire

// *** tb/crc_control_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module crc_control_config_tb;
  localparam logic [31:0] SEED = 32'h12c3_5a8f;
  localparam logic [31:0] WORD = 32'h3132_3334;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] datI = 32'h0;
  logic [31:0] datO;
  logic ack;
  logic [31:0] rq;
  logic [31:0] e;
  logic [1:0] kx;
  int rn;
  int nFail = 0;
  int totalChecks = 0;

  always #50 clk = ~clk;

  crc_control_config #(.ADDR_W(8)) dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; ack and read data are taken at the rising edge that samples ack high
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    rn = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    datI <= d;
    do begin
      @(posedge clk);
      rn++;
    end while (ack !== 1'h1 && rn < 50);
    rq = datO;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
    if (rn >= 50) begin
      nFail++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 4'hf, 32'h0);
  endtask

  task automatic wc(input logic [7:0] c);
    bus(1'h1, crc_pkg::OFF_CTRL, 4'hf, {c, 24'h0});
  endtask

  function automatic logic [31:0] xf(input logic [1:0] c, input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (c == 2'h1 || c == 2'h2) for (int i = 0; i < 32; i++) r[i] = v[(i / 8) * 8 + 7 - i % 8];
    if (c[1]) r = {r[7:0], r[15:8], r[23:16], r[31:24]};
    return r;
  endfunction

  // independent msb-first model of one byte step
  function automatic logic [31:0] crcb(input logic [31:0] c, input logic [7:0] b, input logic w, input logic [31:0] p);
    logic [31:0] r;
    r = w ? c ^ {b, 24'h0} : c ^ {16'h0, b, 8'h0};
    for (int i = 0; i < 8; i++) begin
      if (w) r = r[31] ? (r << 1) ^ p : r << 1;
      else r = (r[15] ? (r << 1) ^ p : r << 1) & 32'h0000_ffff;
    end
    return r;
  endfunction

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    rd(crc_pkg::OFF_CTRL);
    check(rq, 32'h0);
    rd(crc_pkg::OFF_DATA);
    check(rq, crc_pkg::RST_DATA & crc_pkg::HALF_MASK);
    rd(crc_pkg::OFF_POLY);
    check(rq, crc_pkg::RST_POLY);
    rd(8'h0c);
    check(rq, 32'h0);
    wc(8'hff);
    rd(crc_pkg::OFF_CTRL);
    check(rq, 32'hf700_0000);
    // without the top lane enabled a control write leaves the fields alone
    bus(1'h1, crc_pkg::OFF_CTRL, 4'h7, 32'h0);
    rd(crc_pkg::OFF_CTRL);
    check(rq, 32'hf700_0000);
    for (int k = 0; k < 4; k++) begin
      kx = 2'(k);
      wc({kx, 6'h03});
      bus(1'h1, crc_pkg::OFF_DATA, 4'hf, SEED);
      rd(crc_pkg::OFF_DATA);
      check(rq, xf(kx, SEED));
      wc({2'h0, kx, 4'h3});
      rd(crc_pkg::OFF_DATA);
      check(rq, xf(kx, xf(kx, SEED)));
    end
    wc(8'h07);
    bus(1'h1, crc_pkg::OFF_DATA, 4'hf, SEED);
    rd(crc_pkg::OFF_DATA);
    check(rq, ~SEED);
    wc(8'h06);
    bus(1'h1, crc_pkg::OFF_DATA, 4'hf, SEED);
    rd(crc_pkg::OFF_DATA);
    check(rq, {16'h0, ~SEED[15:0]});
    wc(8'h02);
    rd(crc_pkg::OFF_DATA);
    check(rq, {16'h0, SEED[15:0]});
    // 16-bit run over one word then one byte in the lowest lane
    bus(1'h1, crc_pkg::OFF_DATA, 4'hf, 32'hffff_ffff);
    wc(8'h00);
    bus(1'h1, crc_pkg::OFF_DATA, 4'hf, WORD);
    // edges from launch to the ack sample: the taking edge, two per byte, then the ack edge
    check(32'(rn), 32'(2 + crc_pkg::STEP_CYCLES * 4));
    e = 32'h0000_ffff;
    for (int b = 3; b >= 0; b--) e = crcb(e, WORD[8 * b +: 8], 1'h0, 32'h0000_1021);
    rd(crc_pkg::OFF_DATA);
    check(rq, e);
    bus(1'h1, crc_pkg::OFF_DATA, 4'h1, 32'h0000_0035);
    check(32'(rn), 32'(2 + crc_pkg::STEP_CYCLES));
    e = crcb(e, 8'h35, 1'h0, 32'h0000_1021);
    rd(crc_pkg::OFF_DATA);
    check(rq, e);
    // full reversal moves the byte bit-reversed into the top lane
    wc(8'h80);
    bus(1'h1, crc_pkg::OFF_DATA, 4'h1, 32'h0000_0035);
    e = crcb(e, 8'hac, 1'h0, 32'h0000_1021);
    rd(crc_pkg::OFF_DATA);
    check(rq, e);
    // byte reversal moves the byte into the top lane untouched
    wc(8'hc0);
    bus(1'h1, crc_pkg::OFF_DATA, 4'h1, 32'h0000_0035);
    e = crcb(e, 8'h35, 1'h0, 32'h0000_1021);
    rd(crc_pkg::OFF_DATA);
    check(rq, e);
    // in 16-bit mode only the lower polynomial half takes the write
    bus(1'h1, crc_pkg::OFF_POLY, 4'hf, 32'h04c1_1db7);
    rd(crc_pkg::OFF_POLY);
    check(rq, 32'h0000_1db7);
    // 32-bit run; the poly upper half is writable only with width select set
    wc(8'h03);
    bus(1'h1, crc_pkg::OFF_POLY, 4'hf, 32'h04c1_1db7);
    rd(crc_pkg::OFF_POLY);
    check(rq, 32'h04c1_1db7);
    bus(1'h1, crc_pkg::OFF_DATA, 4'hf, 32'hffff_ffff);
    wc(8'h01);
    bus(1'h1, crc_pkg::OFF_DATA, 4'hf, WORD);
    e = 32'hffff_ffff;
    for (int b = 3; b >= 0; b--) e = crcb(e, WORD[8 * b +: 8], 1'h1, 32'h04c1_1db7);
    rd(crc_pkg::OFF_DATA);
    check(rq, e);
    give_verdict();
  end
endmodule // crc_control_config_tb

`default_nettype wire
